// ### rtl/irq_unit_pkg.sv
package irq_unit_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_EXT_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_STD_EN    = 8'ha8;
  localparam logic [7:0] ADDR_STD_PRI   = 8'hb8;
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'hd8;
  localparam logic [7:0] ADDR_EXT_EN    = 8'he8;
  localparam logic [7:0] ADDR_EXT_PRI   = 8'hf8;

  // Source counts and indices in natural priority order
  localparam int NUM_STD  = 6;
  localparam int NUM_EXT  = 5;
  localparam int NUM_SRC  = 11;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_WAKE = 10;

  // Field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int EXT_FLAG_LSB  = 4;
  localparam int WAKE_FLAG_BIT = 3;

  // Fixed read values of reserved bits
  localparam logic [7:0] STD_EN_FIXED   = 8'h00;
  localparam logic [7:0] STD_PRI_FIXED  = 8'h80;
  localparam logic [7:0] EXT_FLAG_FIXED = 8'h08;
  localparam logic [7:0] WAKE_FIXED     = 8'h40;
  localparam logic [7:0] EXT_FIXED      = 8'he0;

  // Reset values
  localparam logic [5:0] STD_RESET  = 6'h00;
  localparam logic [4:0] EXT_RESET  = 5'h00;
  localparam logic [3:0] FLAG_RESET = 4'h0;

  // Instruction cycle phases; external pins sampled at end of the fourth
  localparam logic [1:0] PHASE_RESET  = 2'h0;
  localparam logic [1:0] SAMPLE_PHASE = 2'h3;

  typedef logic [7:0] vec_t;
  typedef logic [3:0] src_idx_t;

  localparam vec_t VECTORS [NUM_SRC] = '{
    8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
    8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63
  };

  typedef enum logic {ST_IDLE, ST_REQ} vec_state_t;

endpackage : irq_unit_pkg

// ### rtl/mcu_interrupt_unit.sv
// Summary of operation
// - External pin 0, active low, edge/level, enable bit 0, vector 0x03
// - External pin 1, active low, edge/level, enable bit 2, vector 0x13
// - Timer 0 at 0x0b via enable bit 1; timer 1 at 0x1b via bit 3
// - Serial rx or tx flag shares vector 0x23, enable bit 4
// - Timer 2 overflow or external flag shares vector 0x2b, enable bit 5
// - Extended sources vector 0x43, 0x4b, 0x53, 0x5b, 0x63 in order
// - Global enable bit 7 masks every source when clear
// - Standard priority bit sits beside its enable; one means high level
// - Extended flags bits 4-7 plus wakeup bit 3; enables/levels bits 0-4
// - Rising address-hit edge sets extended flag bit 7
// - Rising packet-ready edge sets extended flag bit 6
// - SPI byte completion sets extended flag bit 5
// - Rising ADC done edge sets extended flag bit 4
// - Extended flags clear only by software write
// - Software writing a one to an extended flag raises its request
// - Reserved bits read fixed values
// - Level beats natural order; only higher level pre-empts a handler
// - One extra instruction after return or enable/priority write
// - External pins sampled once per instruction at end of phase four
// - Wakeup flag set by events, persists until software clears it
`timescale 1ns/1ps
`default_nettype none

module mcu_interrupt_unit (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       ext_irq0_pin_n_i,
  input  wire logic       ext_irq1_pin_n_i,
  input  wire logic       ext0_edge_mode_i,
  input  wire logic       ext1_edge_mode_i,
  input  wire logic       timer0_overflow_flag_i,
  input  wire logic       timer1_overflow_flag_i,
  input  wire logic       timer2_overflow_flag_i,
  input  wire logic       timer2_external_flag_i,
  input  wire logic       serial_tx_flag_i,
  input  wire logic       serial_rx_flag_i,
  input  wire logic       adc_done_irq_i,
  input  wire logic       spi_done_irq_i,
  input  wire logic       radio_packet_ready_i,
  input  wire logic       radio_address_hit_i,
  input  wire logic       wakeup_event_i,
  input  wire logic       instr_done_i,
  input  wire logic       return_from_irq_i,
  input  wire logic       irq_ack_i,
  output logic            irq_req_o,
  output logic      [7:0] irq_vector_o,
  output logic            ext0_flag_o,
  output logic            ext1_flag_o
);

  localparam int NS = irq_unit_pkg::NUM_SRC;

  logic [5:0]  std_en_q;
  logic        global_en_q;
  logic [5:0]  std_lvl_q;
  logic [4:0]  ext_en_q;
  logic [4:0]  ext_lvl_q;
  logic [3:0]  ext_flags_q;
  logic        wake_q;
  logic [1:0]  phase_q;
  logic [1:0]  ext_samp_q;
  logic [1:0]  ext_prev_q;
  logic [2:0]  rise_prev_q;
  logic        ins_hi_q;
  logic        ins_lo_q;
  logic        hold_q;
  logic        req_lvl_q;
  irq_unit_pkg::src_idx_t   req_src_q;
  irq_unit_pkg::vec_state_t state_q;

  logic        wr_extended_irq_flags;
  logic        wr_wake;
  logic        wr_ctrl;
  logic        sample_en;
  logic        vec_take;
  logic [3:0]  flag_set;
  logic [NS-1:0] pending;
  logic [NS-1:0] enable;
  logic [NS-1:0] level;
  logic [NS-1:0] eligible;
  logic        found;
  logic        found_lvl;
  irq_unit_pkg::src_idx_t best;
  logic [7:0]  rd_mux;

  assign wr_extended_irq_flags = sfr_wr_i && sfr_addr_i == irq_unit_pkg::ADDR_EXT_FLAGS;
  assign wr_wake = sfr_wr_i && sfr_addr_i == irq_unit_pkg::ADDR_WAKE_CTRL;
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == irq_unit_pkg::ADDR_STD_EN ||
                   sfr_addr_i == irq_unit_pkg::ADDR_STD_PRI ||
                   sfr_addr_i == irq_unit_pkg::ADDR_EXT_EN ||
                   sfr_addr_i == irq_unit_pkg::ADDR_EXT_PRI);

  // Control registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      std_en_q    <= irq_unit_pkg::STD_RESET;
      global_en_q <= 1'b0;
      std_lvl_q   <= irq_unit_pkg::STD_RESET;
      ext_en_q    <= irq_unit_pkg::EXT_RESET;
      ext_lvl_q   <= irq_unit_pkg::EXT_RESET;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        irq_unit_pkg::ADDR_STD_EN: begin
          global_en_q <= sfr_wdata_i[irq_unit_pkg::GLOBAL_EN_BIT];
          std_en_q    <= sfr_wdata_i[5:0];
        end
        irq_unit_pkg::ADDR_STD_PRI: std_lvl_q <= sfr_wdata_i[5:0];
        irq_unit_pkg::ADDR_EXT_EN:  ext_en_q  <= sfr_wdata_i[4:0];
        irq_unit_pkg::ADDR_EXT_PRI: ext_lvl_q <= sfr_wdata_i[4:0];
        default: ;
      endcase
    end
  end

  // Instruction phase divider
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= irq_unit_pkg::PHASE_RESET;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign sample_en = phase_q == irq_unit_pkg::SAMPLE_PHASE;

  // External pin sampling and edge flags
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_samp_q <= 2'b11;
      ext_prev_q <= 2'b11;
    end else if (sample_en) begin
      ext_samp_q <= {ext_irq1_pin_n_i, ext_irq0_pin_n_i};
      ext_prev_q <= ext_samp_q;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext0_flag_o <= 1'b0;
      ext1_flag_o <= 1'b0;
    end else begin
      if (!ext0_edge_mode_i) begin
        ext0_flag_o <= !ext_samp_q[0];
      end else if (ext_prev_q[0] && !ext_samp_q[0] && sample_en) begin
        ext0_flag_o <= 1'b1;
      end else if (irq_ack_i && state_q == irq_unit_pkg::ST_REQ &&
                   req_src_q == 4'(irq_unit_pkg::SRC_EXT0)) begin
        ext0_flag_o <= 1'b0;
      end
      if (!ext1_edge_mode_i) begin
        ext1_flag_o <= !ext_samp_q[1];
      end else if (ext_prev_q[1] && !ext_samp_q[1] && sample_en) begin
        ext1_flag_o <= 1'b1;
      end else if (irq_ack_i && state_q == irq_unit_pkg::ST_REQ &&
                   req_src_q == 4'(irq_unit_pkg::SRC_EXT1)) begin
        ext1_flag_o <= 1'b0;
      end
    end
  end

  // Extended flag sources
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rise_prev_q <= 3'h0;
    end else begin
      rise_prev_q <= {radio_address_hit_i, radio_packet_ready_i,
                      adc_done_irq_i};
    end
  end

  assign flag_set[0] = adc_done_irq_i && !rise_prev_q[0];
  assign flag_set[1] = spi_done_irq_i;
  assign flag_set[2] = radio_packet_ready_i && !rise_prev_q[1];
  assign flag_set[3] = radio_address_hit_i && !rise_prev_q[2];

  // Set wins over a software write of zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_flags_q <= irq_unit_pkg::FLAG_RESET;
    end else if (wr_extended_irq_flags) begin
      ext_flags_q <= sfr_wdata_i[7:irq_unit_pkg::EXT_FLAG_LSB] |
                     flag_set;
    end else begin
      ext_flags_q <= ext_flags_q | flag_set;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_q <= 1'b0;
    end else if (wr_wake) begin
      wake_q <= sfr_wdata_i[irq_unit_pkg::WAKE_FLAG_BIT] ||
                wakeup_event_i;
    end else if (wakeup_event_i) begin
      wake_q <= 1'b1;
    end
  end

  // Source table
  assign pending = {wake_q, ext_flags_q,
                    timer2_overflow_flag_i | timer2_external_flag_i,
                    serial_rx_flag_i | serial_tx_flag_i,
                    timer1_overflow_flag_i, ext1_flag_o,
                    timer0_overflow_flag_i, ext0_flag_o};
  assign enable  = {ext_en_q, std_en_q};
  assign level   = {ext_lvl_q, std_lvl_q};

  generate
    for (genvar i = 0; i < NS; i++) begin : g_src
      assign eligible[i] = global_en_q && enable[i] && pending[i] &&
                           (level[i] ? !ins_hi_q
                                     : !(ins_hi_q || ins_lo_q));
    end
  endgenerate

  // Level first, then lowest natural index
  always_comb begin
    found     = 1'b0;
    found_lvl = 1'b0;
    best      = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (eligible[i] && level[i]) begin
        found     = 1'b1;
        found_lvl = 1'b1;
        best      = 4'(i);
      end
    end
    if (!found_lvl) begin
      for (int i = NS - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          found = 1'b1;
          best  = 4'(i);
        end
      end
    end
  end

  // One-instruction hold after return or control write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_q <= 1'b0;
    end else if (return_from_irq_i || wr_ctrl) begin
      hold_q <= 1'b1;
    end else if (instr_done_i) begin
      hold_q <= 1'b0;
    end
  end

  assign vec_take = state_q == irq_unit_pkg::ST_IDLE && instr_done_i &&
                    !hold_q && found;

  // Vector request to the core
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q      <= irq_unit_pkg::ST_IDLE;
      irq_req_o    <= 1'b0;
      irq_vector_o <= 8'h00;
      req_src_q    <= '0;
      req_lvl_q    <= 1'b0;
    end else begin
      case (state_q)
        irq_unit_pkg::ST_IDLE: begin
          if (vec_take) begin
            state_q      <= irq_unit_pkg::ST_REQ;
            irq_req_o    <= 1'b1;
            irq_vector_o <= irq_unit_pkg::VECTORS[best];
            req_src_q    <= best;
            req_lvl_q    <= level[best];
          end
        end
        irq_unit_pkg::ST_REQ: begin
          if (irq_ack_i) begin
            state_q   <= irq_unit_pkg::ST_IDLE;
            irq_req_o <= 1'b0;
          end
        end
        default: begin
          state_q   <= irq_unit_pkg::ST_IDLE;
          irq_req_o <= 1'b0;
        end
      endcase
    end
  end

  // In-service tracking
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ins_hi_q <= 1'b0;
      ins_lo_q <= 1'b0;
    end else if (irq_ack_i && state_q == irq_unit_pkg::ST_REQ) begin
      if (req_lvl_q) begin
        ins_hi_q <= 1'b1;
      end else begin
        ins_lo_q <= 1'b1;
      end
    end else if (return_from_irq_i) begin
      if (ins_hi_q) begin
        ins_hi_q <= 1'b0;
      end else begin
        ins_lo_q <= 1'b0;
      end
    end
  end

  // Register read
  always_comb begin
    case (sfr_addr_i)
      irq_unit_pkg::ADDR_STD_EN:
        rd_mux = irq_unit_pkg::STD_EN_FIXED |
                 {global_en_q, 1'b0, std_en_q};
      irq_unit_pkg::ADDR_STD_PRI:
        rd_mux = irq_unit_pkg::STD_PRI_FIXED | {2'b00, std_lvl_q};
      irq_unit_pkg::ADDR_EXT_FLAGS:
        rd_mux = irq_unit_pkg::EXT_FLAG_FIXED | {ext_flags_q, 4'h0};
      irq_unit_pkg::ADDR_WAKE_CTRL:
        rd_mux = irq_unit_pkg::WAKE_FIXED | {4'h0, wake_q, 3'h0};
      irq_unit_pkg::ADDR_EXT_EN:
        rd_mux = irq_unit_pkg::EXT_FIXED | {3'h0, ext_en_q};
      irq_unit_pkg::ADDR_EXT_PRI:
        rd_mux = irq_unit_pkg::EXT_FIXED | {3'h0, ext_lvl_q};
      default:
        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ext0_vector_a: assert property ($rose(irq_req_o) &&
      irq_vector_o == irq_unit_pkg::VECTORS[irq_unit_pkg::SRC_EXT0]
      |-> $past(pending[0]) && $past(enable[0]))
    else $error("ext0 vector without pending pin");
  global_mask_a: assert property ($rose(irq_req_o)
      |-> $past(global_en_q))
    else $error("request while globally masked");
  addr_hit_flag_a: assert property ($rose(radio_address_hit_i)
      |=> ext_flags_q[3])
    else $error("address hit edge lost");
  spi_flag_a: assert property (spi_done_irq_i |=> ext_flags_q[1])
    else $error("spi completion lost");
  flag_clear_a: assert property ($fell(ext_flags_q[2])
      |-> $past(wr_extended_irq_flags))
    else $error("extended flag cleared without write");
  pri_reserved_a: assert property (sfr_rd_i &&
      sfr_addr_i == irq_unit_pkg::ADDR_STD_PRI
      |=> sfr_rdata_o[7:6] == 2'b10)
    else $error("priority reserved bits wrong");
  preempt_level_a: assert property ($rose(irq_req_o)
      |-> !$past(ins_hi_q) && (!$past(ins_lo_q) || req_lvl_q))
    else $error("request breaks level pre-emption");
  hold_block_a: assert property (instr_done_i && hold_q
      |=> !$rose(irq_req_o))
    else $error("vector taken during hold");
  pin_sample_a: assert property (ext_samp_q != $past(ext_samp_q)
      |-> $past(phase_q) == irq_unit_pkg::SAMPLE_PHASE)
    else $error("pin sampled off phase");
  wake_set_a: assert property (wakeup_event_i
      |=> wake_q [*2] or (wake_q ##1 $past(wr_wake)))
    else $error("wakeup flag lost");

  ack_cover_c: cover property ($rose(irq_req_o) ##[1:8] irq_ack_i);
  preempt_cover_c: cover property (ins_lo_q && $rose(irq_req_o));
  soft_flag_cover_c: cover property (wr_extended_irq_flags ##1 $rose(irq_req_o));

endmodule : mcu_interrupt_unit

`default_nettype wire

// ### tb/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       run_i,
  input  wire logic       slow_i,
  input  wire logic       irq_req_i,
  input  wire logic [7:0] irq_vector_i,
  output logic            instr_done_o,
  output logic            irq_ack_o,
  output logic            took_o,
  output logic      [7:0] took_vec_o
);
  logic [1:0] phase_q;
  logic [1:0] wait_q;

  // One completed instruction every fourth cycle while running
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q      <= 2'h0;
      instr_done_o <= 1'b0;
    end else begin
      phase_q      <= run_i ? phase_q + 2'h1 : 2'h0;
      instr_done_o <= run_i && (phase_q == 2'h3);
    end
  end

  // Acknowledge at once or after three cycles, only while requested
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q     <= 2'h0;
      irq_ack_o  <= 1'b0;
      took_o     <= 1'b0;
      took_vec_o <= 8'h00;
    end else if (irq_req_i && !irq_ack_o) begin
      if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
        irq_ack_o  <= 1'b1;
        took_o     <= 1'b1;
        took_vec_o <= irq_vector_i;
        wait_q     <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end else begin
      irq_ack_o <= 1'b0;
      took_o    <= 1'b0;
    end
  end
endmodule : cpu_core_model

`default_nettype wire

// ### tb/mcu_interrupt_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mcu_interrupt_unit_tb;
  logic       clk_i  = 1'b0;
  logic       nrst_i = 1'b0;
  logic [7:0] addr   = 8'h00;
  logic [7:0] wdata  = 8'h00;
  logic       wr_s   = 1'b0;
  logic       rd_s   = 1'b0;
  logic [1:0] pin_n  = 2'h3;
  logic [1:0] mode   = 2'h0;
  logic [5:0] lvl    = 6'h00;
  logic [4:0] src    = 5'h00;
  logic       rti    = 1'b0;
  logic       run    = 1'b0;
  logic       slow   = 1'b0;
  logic [7:0] rdata;
  logic [7:0] vec;
  logic [7:0] took_vec;
  logic       done, ack, req, took, flag0, flag1;
  int         n_fail    = 0;
  int         cmp_count = 0;
  int         cyc       = 0;
  logic [7:0] ra [7] = '{8'h91, 8'ha8, 8'hb8, 8'hd8, 8'he8, 8'hf8, 8'h00};
  logic [7:0] r0 [7] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'he0, 8'he0, 8'h00};
  logic [7:0] rf [7] = '{8'hf8, 8'hbf, 8'hbf, 8'h48, 8'hff, 8'hff, 8'h00};
  int         ieb [6] = '{1, 3, 4, 4, 5, 5};
  logic [7:0] sv [6] = '{8'h0b, 8'h1b, 8'h23, 8'h23, 8'h2b, 8'h2b};
  logic [7:0] ev [5] = '{8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};

  always #50 clk_i = ~clk_i;

  mcu_interrupt_unit dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr), .sfr_wr_i(wr_s),
    .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .ext_irq0_pin_n_i(pin_n[0]), .ext_irq1_pin_n_i(pin_n[1]),
    .ext0_edge_mode_i(mode[0]), .ext1_edge_mode_i(mode[1]),
    .timer0_overflow_flag_i(lvl[0]), .timer1_overflow_flag_i(lvl[1]),
    .serial_tx_flag_i(lvl[2]), .serial_rx_flag_i(lvl[3]),
    .timer2_overflow_flag_i(lvl[4]), .timer2_external_flag_i(lvl[5]),
    .adc_done_irq_i(src[0]), .spi_done_irq_i(src[1]),
    .radio_packet_ready_i(src[2]), .radio_address_hit_i(src[3]),
    .wakeup_event_i(src[4]), .instr_done_i(done),
    .return_from_irq_i(rti), .irq_ack_i(ack), .irq_req_o(req),
    .irq_vector_o(vec), .ext0_flag_o(flag0), .ext1_flag_o(flag1));

  cpu_core_model cpu_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .run_i(run), .slow_i(slow),
    .irq_req_i(req), .irq_vector_i(vec), .instr_done_o(done),
    .irq_ack_o(ack), .took_o(took), .took_vec_o(took_vec));

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_s = 1'b1;
    tick(1);
    rd_s = 1'b0;
    tick(1);
    chk(rdata, exp);
  endtask : rd

  // Let the core run until it takes a vector, bounded
  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    run = 1'b1;
    while (took !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    run = 1'b0;
    // Let the acknowledge reach the unit before anything else moves
    tick(1);
    chk((n < 80) ? took_vec : 8'hxx, exp);
  endtask : take

  // Let the core run and expect no vector at all
  task automatic quiet(input int n);
    logic hit;
    hit = 1'b0;
    run = 1'b1;
    repeat (n) begin
      tick(1);
      if (took === 1'b1) hit = 1'b1;
    end
    run = 1'b0;
    chk({7'h00, hit | req}, 8'h00);
  endtask : quiet

  task automatic ret();
    rti = 1'b1;
    tick(1);
    rti = 1'b0;
  endtask : ret

  task automatic endt(input string name);
    $display("test %s done, %0d mismatches so far", name, n_fail);
  endtask : endt

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    tick(4);
    nrst_i = 1'b1;
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 7; i++) begin
        if (p > 0) wr(ra[i], (p == 1) ? 8'hff : 8'h00);
        rd(ra[i], (p == 1) ? rf[i] : r0[i]);
      end
    end
    endt("registers");
    for (int i = 0; i < 6; i++) begin
      slow = i[0];
      wr(8'ha8, 8'h01 << ieb[i]);
      lvl = 6'h01 << i;
      quiet(16);
      wr(8'ha8, 8'h80 | (8'h01 << ieb[i]));
      take(sv[i]);
      lvl = 6'h00;
      ret();
    end
    endt("standard sources");
    mode = 2'b10;
    wr(8'ha8, 8'h81);
    pin_n = 2'b10;
    take(8'h03);
    chk({7'h00, flag0}, 8'h01);
    pin_n = 2'b11;
    tick(8);
    ret();
    wr(8'ha8, 8'h84);
    pin_n = 2'b01;
    tick(8);
    pin_n = 2'b11;
    tick(8);
    chk({7'h00, flag1}, 8'h01);
    take(8'h13);
    ret();
    chk({7'h00, flag1}, 8'h00);
    wr(8'ha8, 8'h81);
    mode = 2'b01;
    pin_n = 2'b10;
    tick(8);
    pin_n = 2'b11;
    take(8'h03);
    chk({7'h00, flag0}, 8'h00);
    ret();
    endt("external pins");
    wr(8'ha8, 8'h92);
    lvl = 6'h05;
    take(8'h0b);
    lvl = 6'h04;
    ret();
    take(8'h23);
    lvl = 6'h00;
    ret();
    wr(8'hb8, 8'h10);
    lvl = 6'h05;
    take(8'h23);
    quiet(16);
    lvl = 6'h01;
    ret();
    take(8'h0b);
    lvl = 6'h04;
    take(8'h23);
    lvl = 6'h00;
    ret();
    tick(1);
    ret();
    wr(8'hb8, 8'h00);
    endt("priority");
    wr(8'ha8, 8'h80);
    for (int i = 0; i < 5; i++) begin
      src = 5'h01 << i;
      tick(1);
      src = 5'h00;
      tick(3);
      rd((i < 4) ? 8'h91 : 8'hd8, (i < 4) ? 8'h08 | (8'h10 << i) : 8'h48);
      wr(8'he8, 8'h01 << i);
      take(ev[i]);
      if (i == 4) begin
        ret();
        take(8'h63);
      end
      wr((i < 4) ? 8'h91 : 8'hd8, 8'h00);
      ret();
      quiet(12);
    end
    wr(8'h91, 8'h40);
    wr(8'he8, 8'h04);
    take(8'h53);
    wr(8'h91, 8'h00);
    ret();
    wr(8'he8, 8'h00);
    endt("extended sources");
    wrap_up();
  end
endmodule : mcu_interrupt_unit_tb

`default_nettype wire
